// file: rtl/dpllf_top.sv
// digital pll feedback path: divider, phase detector, loop filter
// assumes pins are asynchronous to i_clk and sampled well above rate
// Operation
// RULE1: 16-bit feedback counter, optional halving stage
// RULE2: divider counts on selectable feedback edge
// RULE3: stored modulus is ratio minus one
// RULE4: halving needed above 400 MHz feedback
// RULE5: modulus kept below counter and 40% limits
// RULE6: modulus keeps oscillator above minimum, at least one
// RULE7: coarse and fine detectors measure pulse width
// RULE8: fine result used unless over or underflow
// RULE9: filter integrates and low-passes phase error
// RULE10: one error sample per reference period
// RULE11: 5-bit exponent sets decimation two-power
// RULE12: decimation spans 32 to 65536
// RULE13: interpolator raises rate to sample rate
// RULE14: interpolator unity dc gain, nulls at fs/P
// RULE15: decimation chosen for first null placement
// RULE16: exponent below maximum for phase margin
// RULE17: oscillator frequency linear in tuning word
// RULE18: 48-bit tuning word added every cycle
// RULE19: control bit selects closed or open loop
// RULE20: two cic stages normalised by P squared
// RULE21: free-running counter makes decimation strobe
`timescale 1ns/1ps
module dpllf_top (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // link pins
    input wire logic i_ref_pre,
    input wire logic i_feedback_input,
    // fine detector macro
    input wire logic i_fine_valid,
    input wire logic i_fine_ovf,
    input wire logic i_fine_unf,
    input wire logic [15:0] i_fine_err,
    // synthesizer side
    output logic [47:0] o_tuning_word,
    output logic [47:0] o_phase
);
    logic closed_r, halve_r, fall_r;
    logic [15:0] fbmod_r;
    logic [4:0] decexp_r, kp_r, ki_r;
    logic [47:0] tw_open_r;
    logic ref_s1, ref_s2, ref_s3, fb_s1, fb_s2, fb_s3;
    logic ref_evt, fb_edge, div_tick, fb_evt, half_r;
    logic [15:0] cnt_r;
    logic up_r, dn_r, up_n, dn_n, pfd_done;
    logic [23:0] tdc_cnt_r;
    logic signed [23:0] coarse_err, fine_ext, sel_err, err_r;
    logic fine_ok_r, sel_fine_r, err_new_r;
    logic signed [15:0] fine_r;
    logic [4:0] exp_eff;
    logic [15:0] pm1, dec_cnt_r;
    logic strobe;
    logic signed [47:0] e48, integ_r, lp_r, prop, lp_in, filt;
    dpllf_interp_if lnk ();

    // registers written by software
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            closed_r <= 1'b0;
            halve_r <= 1'b0;
            fall_r <= 1'b0;
            fbmod_r <= dpllf_pkg::FBMOD_RST;
            decexp_r <= dpllf_pkg::DECEXP_RST;
            kp_r <= dpllf_pkg::KP_RST;
            ki_r <= dpllf_pkg::KI_RST;
            tw_open_r <= dpllf_pkg::TW_RST;
        end
        else if (i_ce && i_wr)
        begin
            unique case (i_addr)
                dpllf_pkg::ADDR_CTRL:
                    closed_r <= i_wdata[dpllf_pkg::CTRL_CLOSED_BIT];
                dpllf_pkg::ADDR_FBMOD: fbmod_r <= i_wdata[15:0];
                dpllf_pkg::ADDR_FBCFG:
                begin
                    halve_r <= i_wdata[dpllf_pkg::FBCFG_HALVE_BIT];
                    fall_r <= i_wdata[dpllf_pkg::FBCFG_FALL_BIT];
                end
                dpllf_pkg::ADDR_DECEXP: decexp_r <= i_wdata[4:0];
                dpllf_pkg::ADDR_GAIN:
                begin
                    kp_r <= i_wdata[dpllf_pkg::GAIN_KP_LSB +: 5];
                    ki_r <= i_wdata[dpllf_pkg::GAIN_KI_LSB +: 5];
                end
                dpllf_pkg::ADDR_TWLO: tw_open_r[31:0] <= i_wdata;
                dpllf_pkg::ADDR_TWHI: tw_open_r[47:32] <= i_wdata[15:0];
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= 32'h0;
        else if (i_ce)
        begin
            o_rdata <= 32'h0;
            if (i_rd)
            begin
                unique case (i_addr)
                    dpllf_pkg::ADDR_CTRL: o_rdata <= {31'h0, closed_r};
                    dpllf_pkg::ADDR_FBMOD: o_rdata <= {16'h0, fbmod_r};
                    dpllf_pkg::ADDR_FBCFG: o_rdata <= {30'h0, fall_r, halve_r};
                    dpllf_pkg::ADDR_DECEXP: o_rdata <= {27'h0, decexp_r};
                    dpllf_pkg::ADDR_GAIN:
                        o_rdata <= {19'h0, ki_r, 3'h0, kp_r};
                    dpllf_pkg::ADDR_TWLO: o_rdata <= tw_open_r[31:0];
                    dpllf_pkg::ADDR_TWHI: o_rdata <= {16'h0, tw_open_r[47:32]};
                    dpllf_pkg::ADDR_STAT:
                        o_rdata <= {28'h0, fine_ok_r, dn_r, up_r, sel_fine_r};
                    dpllf_pkg::ADDR_TWRLO: o_rdata <= o_tuning_word[31:0];
                    dpllf_pkg::ADDR_TWRHI:
                        o_rdata <= {16'h0, o_tuning_word[47:32]};
                    default: o_rdata <= 32'h0;
                endcase
            end
        end
    end

    // pin synchronisers, third stage only for edge finding
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            {ref_s1, ref_s2, ref_s3, fb_s1, fb_s2, fb_s3} <= 6'h0;
        else if (i_ce)
        begin
            ref_s1 <= i_ref_pre;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            fb_s1 <= i_feedback_input;
            fb_s2 <= fb_s1;
            fb_s3 <= fb_s2;
        end
    end

    assign ref_evt = ref_s2 && !ref_s3;
    assign fb_edge = fall_r ? (fb_s3 && !fb_s2) : (fb_s2 && !fb_s3); // [RULE2]
    // modulus m divides by m+1; >= survives a modulus lowered mid-count
    assign div_tick = fb_edge && (cnt_r >= fbmod_r); // [RULE3]
    assign fb_evt = div_tick && (!halve_r || half_r); // [RULE1]

    // feedback counter and halving stage
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_r <= 16'h0;
            half_r <= 1'b0;
        end
        else if (i_ce && fb_edge)
        begin
            cnt_r <= div_tick ? 16'h0 : cnt_r + 16'h1; // [RULE1]
            if (div_tick)
                half_r <= halve_r ? !half_r : 1'b0;
        end
    end

    // three-state detector, coarse width counted in sample clocks
    assign up_n = up_r || ref_evt;
    assign dn_n = dn_r || fb_evt;
    assign pfd_done = up_n && dn_n;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
            tdc_cnt_r <= 24'h0;
        end
        else if (i_ce)
        begin
            if (pfd_done)
            begin
                up_r <= 1'b0; // [RULE7]
                dn_r <= 1'b0;
                tdc_cnt_r <= 24'h0;
            end
            else
            begin
                up_r <= up_n;
                dn_r <= dn_n;
                if ((up_n || dn_n) && tdc_cnt_r != 24'hffffff)
                    tdc_cnt_r <= tdc_cnt_r + 24'h1;
            end
        end
    end

    // latest fine result and whether it is in range
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fine_r <= 16'sh0;
            fine_ok_r <= 1'b0;
        end
        else if (i_ce && i_fine_valid)
        begin
            fine_r <= i_fine_err;
            fine_ok_r <= !i_fine_ovf && !i_fine_unf; // [RULE8]
        end
    end

    assign coarse_err = up_r ? $signed(tdc_cnt_r)
                      : dn_r ? -$signed(tdc_cnt_r) : 24'sh0; // [RULE7]
    assign fine_ext = 24'(fine_r);
    assign sel_err = fine_ok_r ? fine_ext : coarse_err; // [RULE8]

    // one sample per reference period; a new sample beats the strobe
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            err_r <= 24'sh0;
            err_new_r <= 1'b0;
            sel_fine_r <= 1'b0;
        end
        else if (i_ce)
        begin
            if (pfd_done)
            begin
                err_r <= sel_err; // [RULE10]
                sel_fine_r <= fine_ok_r;
                err_new_r <= 1'b1;
            end
            else if (strobe)
                err_new_r <= 1'b0;
        end
    end

    // decimation strobe from a free-running counter
    assign exp_eff = (decexp_r < dpllf_pkg::EXP_MIN) ? dpllf_pkg::EXP_MIN
                   : (decexp_r > dpllf_pkg::EXP_MAX) ? dpllf_pkg::EXP_MAX
                   : decexp_r; // [RULE12]
    assign pm1 = 16'((17'h1 << exp_eff) - 17'h1); // [RULE11]
    assign strobe = dec_cnt_r >= pm1;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            dec_cnt_r <= 16'h0;
        else if (i_ce)
            dec_cnt_r <= strobe ? 16'h0 : dec_cnt_r + 16'h1; // [RULE21]
    end

    // pi filter with a further pole: charge pump into second-order rc
    assign e48 = (err_new_r && closed_r) ? 48'(err_r) : 48'sh0;
    assign prop = e48 <<< kp_r;
    assign lp_in = prop + integ_r;
    assign filt = $signed(tw_open_r) + lp_r;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            integ_r <= 48'sh0;
            lp_r <= 48'sh0;
        end
        else if (i_ce && !closed_r)
        begin
            integ_r <= 48'sh0;
            lp_r <= 48'sh0;
        end
        else if (i_ce && strobe)
        begin
            integ_r <= integ_r + (e48 <<< ki_r); // [RULE9]
            lp_r <= lp_r + ((lp_in - lp_r) >>> dpllf_pkg::LP_SHIFT);
        end
    end

    assign lnk.strobe = strobe;
    assign lnk.exp = exp_eff;
    assign lnk.din = filt;

    dpllf_interp u_interp (
        .i_clk (i_clk),
        .i_arst_n (i_arst_n),
        .i_ce (i_ce),
        .lnk (lnk.dst)
    );

    // tuning word source and phase accumulator
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_tuning_word <= 48'h0;
            o_phase <= 48'h0;
        end
        else if (i_ce)
        begin
            o_tuning_word <= closed_r ? lnk.dout : tw_open_r; // [RULE19]
            o_phase <= o_phase + o_tuning_word; // [RULE18] [RULE17]
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    div_wrap_a: assert property ((i_ce && div_tick) |=> cnt_r == 16'h0) // [RULE3]
        else $error("feedback counter did not wrap");
    div_one_a: assert property ((fb_edge && fbmod_r == 16'h0 && !halve_r)
        |-> fb_evt) // [RULE1]
        else $error("modulus zero did not divide by one");
    edge_sel_a: assert property ((fb_edge && !fall_r) |-> fb_s2 && !fb_s3) // [RULE2]
        else $error("wrong feedback edge used");
    pfd_clear_a: assert property ((i_ce && pfd_done)
        |=> !up_r && !dn_r && tdc_cnt_r == 24'h0) // [RULE7]
        else $error("detector pulse not cleared");
    fine_pick_a: assert property ((i_ce && pfd_done && fine_ok_r)
        |=> err_r == $past(fine_ext) && sel_fine_r) // [RULE8]
        else $error("fine result not chosen");
    coarse_pick_a: assert property ((i_ce && pfd_done && !fine_ok_r)
        |=> err_r == $past(coarse_err)) // [RULE8]
        else $error("coarse result not chosen");
    sample_flag_a: assert property ((i_ce && pfd_done) |=> err_new_r) // [RULE10]
        else $error("error sample lost");
    exp_span_a: assert property (exp_eff >= 5'h05 && exp_eff <= 5'h10) // [RULE12]
        else $error("decimation exponent out of span");
    strobe_period_a: assert property ((i_ce && strobe) |=> dec_cnt_r == 16'h0
        ##1 !strobe [*5]) // [RULE21] [RULE11]
        else $error("decimation strobe too frequent");
    open_word_a: assert property ((i_ce && !closed_r)
        |=> o_tuning_word == $past(tw_open_r)) // [RULE19]
        else $error("open loop word not applied");
    accum_a: assert property (i_ce |=> o_phase == $past(o_phase)
        + $past(o_tuning_word)) // [RULE18]
        else $error("phase accumulator step wrong");

    fine_used_c: cover property (i_ce && pfd_done && fine_ok_r);
    coarse_used_c: cover property (i_ce && pfd_done && !fine_ok_r);
    closed_strobe_c: cover property (closed_r && strobe && err_new_r);
    halved_c: cover property (halve_r && fb_evt);
endmodule : dpllf_top

// file: common/dpllf_pkg.sv
// constants for the digital pll feedback loop
// assumes a 100 MHz sample clock and a plain register port
package dpllf_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h100;
    localparam logic [11:0] ADDR_FBMOD = 12'h104;
    localparam logic [11:0] ADDR_FBCFG = 12'h108;
    localparam logic [11:0] ADDR_DECEXP = 12'h10c;
    localparam logic [11:0] ADDR_GAIN = 12'h110;
    localparam logic [11:0] ADDR_TWLO = 12'h114;
    localparam logic [11:0] ADDR_TWHI = 12'h118;
    localparam logic [11:0] ADDR_STAT = 12'h11c;
    localparam logic [11:0] ADDR_TWRLO = 12'h120;
    localparam logic [11:0] ADDR_TWRHI = 12'h124;
    // field positions
    localparam int CTRL_CLOSED_BIT = 0;
    localparam int FBCFG_HALVE_BIT = 0;
    localparam int FBCFG_FALL_BIT = 1;
    localparam int GAIN_KP_LSB = 0;
    localparam int GAIN_KI_LSB = 8;
    // reset values
    localparam logic [15:0] FBMOD_RST = 16'h0000;
    localparam logic [4:0] DECEXP_RST = 5'h05;
    localparam logic [4:0] KP_RST = 5'h04;
    localparam logic [4:0] KI_RST = 5'h08;
    localparam logic [47:0] TW_RST = 48'h0;
    // decimation exponent limits
    localparam logic [4:0] EXP_MIN = 5'h05;
    localparam logic [4:0] EXP_MAX = 5'h10;
    // widths and smoothing of the second filter pole
    localparam int TW_W = 48;
    localparam int ERR_W = 24;
    localparam int FINE_W = 16;
    localparam int CIC_W = 84;
    localparam int LP_SHIFT = 2;
endpackage : dpllf_pkg

// file: common/dpllf_interp_if.sv
// link between loop filter and rate interpolator
// assumes both ends run on the sample clock
`timescale 1ns/1ps
interface dpllf_interp_if;
    logic strobe;
    logic [4:0] exp;
    logic signed [47:0] din;
    logic [47:0] dout;
    modport src (output strobe, output exp, output din, input dout);
    modport dst (input strobe, input exp, input din, output dout);
endinterface : dpllf_interp_if

// file: rtl/dpllf_interp.sv
// second-order comb-integrator rate interpolator
// assumes strobe comes every 2**exp cycles and exp is 5..16
`timescale 1ns/1ps
module dpllf_interp (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // filter side
    dpllf_interp_if.dst lnk
);
    localparam int W = dpllf_pkg::CIC_W;
    logic signed [W-1:0] x_d_r, c1_d_r, int1_r, int2_r, dout_ext;
    logic signed [W-1:0] x, c1, c2, stuff;
    logic [4:0] exp_d_r;
    logic reload;

    assign x = W'(lnk.din);
    // a new decimation setting would leave the chain scaled by the old P
    assign reload = lnk.exp != exp_d_r;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            exp_d_r <= dpllf_pkg::EXP_MIN;
        else if (i_ce)
            exp_d_r <= lnk.exp;
    end
    assign c1 = x - x_d_r;
    assign c2 = c1 - c1_d_r;
    // zero stuffing scaled by P so total gain is P squared
    assign stuff = lnk.strobe ? (c2 <<< lnk.exp) : '0; // [RULE20]

    // combs at the decimated rate
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            x_d_r <= '0;
            c1_d_r <= '0;
        end
        else if (i_ce && reload)
        begin
            x_d_r <= x;
            c1_d_r <= '0;
        end
        else if (i_ce && lnk.strobe)
        begin
            x_d_r <= x; // [RULE13]
            c1_d_r <= c1;
        end
    end

    // integrators at the full sample rate
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            int1_r <= '0;
            int2_r <= '0;
        end
        else if (i_ce && reload)
        begin
            // restart settled at the present input under the new scale
            int1_r <= '0;
            int2_r <= x <<< {lnk.exp, 1'b0}; // [RULE14]
        end
        else if (i_ce)
        begin
            int1_r <= int1_r + stuff; // [RULE13]
            int2_r <= int2_r + int1_r;
        end
    end

    // normalise by P squared for unity dc gain
    assign dout_ext = int2_r >>> {lnk.exp, 1'b0}; // [RULE14] [RULE20]

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            lnk.dout <= '0;
        else if (i_ce && !reload)
            lnk.dout <= dout_ext[47:0];
    end

    comb_hold_a: assert property ( // [RULE13]
        @(posedge i_clk) disable iff (!i_arst_n)
        (!lnk.strobe && !reload) |=> x_d_r == $past(x_d_r))
        else $error("interpolator comb moved between strobes");
endmodule : dpllf_interp

// file: tb/dpllf_partner.sv
// model of the pins driven from outside: prescaled reference and feedback
// assumes the bench calls its tasks; both pins idle low between bursts
`timescale 1ns/1ps
module dpllf_partner (
    // pins toward the block
    output logic o_ref_pre,
    output logic o_feedback_input
);
    initial
    begin
        o_ref_pre = 1'b0;
        o_feedback_input = 1'b0;
    end

    // one half period of the 125 ns feedback, well below the halving limit
    task automatic fb_level(input logic v);
        #62.5 o_feedback_input = v;
    endtask : fb_level

    task automatic fb_edges(input int n);
        // small offset keeps every pin change clear of the clock edges
        #1.25;
        repeat (n)
        begin
            fb_level(1'b1);
            fb_level(1'b0);
        end
    endtask : fb_edges

    // reference edge long enough for the synchroniser
    task automatic ref_pulse();
        #42 o_ref_pre = 1'b1;
        #100 o_ref_pre = 1'b0;
    endtask : ref_pulse
endmodule : dpllf_partner

// file: tb/dpllf_top_test.sv
// self-checking bench for the digital pll feedback loop
// assumes dpllf_top with the register map of dpllf_pkg
`timescale 1ns/1ps
module dpllf_top_test;
    logic i_clk;
    logic i_arst_n;
    logic i_ce;
    logic [11:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic i_ref_pre;
    logic i_feedback_input;
    logic i_fine_valid;
    logic i_fine_ovf;
    logic i_fine_unf;
    logic [15:0] i_fine_err;
    logic [47:0] o_tuning_word;
    logic [47:0] o_phase;
    int n_mismatch;
    int check_count;

    dpllf_top i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_ref_pre(i_ref_pre),
        .i_feedback_input(i_feedback_input), .i_fine_valid(i_fine_valid),
        .i_fine_ovf(i_fine_ovf), .i_fine_unf(i_fine_unf),
        .i_fine_err(i_fine_err), .o_tuning_word(o_tuning_word),
        .o_phase(o_phase));
    dpllf_partner i_partner (.o_ref_pre(i_ref_pre),
        .o_feedback_input(i_feedback_input));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [47:0] got, input logic [47:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk);
    endtask : rd

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk({16'h0, d}, {16'h0, e}, "read");
    endtask : rdchk

    task automatic do_reset();
        i_arst_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
    endtask : do_reset

    task automatic wait_tw(input logic [47:0] t, input int lim, output int n);
        n = 0;
        while (o_tuning_word !== t && n < lim)
        begin
            @(posedge i_clk);
            #1 n++;
        end
    endtask : wait_tw

    task automatic t_regs();
        do_reset();
        chk(o_phase | o_tuning_word, 48'h0, "reset out");
        rdchk(dpllf_pkg::ADDR_CTRL, 32'h0);
        rdchk(dpllf_pkg::ADDR_FBMOD, 32'h0);
        rdchk(dpllf_pkg::ADDR_FBCFG, 32'h0);
        rdchk(dpllf_pkg::ADDR_DECEXP, {27'h0, dpllf_pkg::DECEXP_RST});
        rdchk(dpllf_pkg::ADDR_GAIN, {19'h0, dpllf_pkg::KI_RST, 3'h0,
            dpllf_pkg::KP_RST});
        rdchk(dpllf_pkg::ADDR_TWHI, 32'h0);
        #1 chk({16'h0, o_rdata}, 48'h0, "rdata idle");
        wr(dpllf_pkg::ADDR_FBMOD, 32'h0000_beef);
        rdchk(dpllf_pkg::ADDR_FBMOD, 32'h0000_beef);
        wr(dpllf_pkg::ADDR_DECEXP, 32'h10);
        rdchk(dpllf_pkg::ADDR_DECEXP, 32'h10);
        wr(12'h200, 32'hffff_ffff);
        rdchk(12'h200, 32'h0);
        wr(dpllf_pkg::ADDR_TWRLO, 32'hffff_ffff);
        rdchk(dpllf_pkg::ADDR_TWRLO, 32'h0);
    endtask : t_regs

    task automatic t_open();
        logic [47:0] tw;
        logic [47:0] p0;
        int n;
        tw = 48'h4567_89ab_cdef;
        do_reset();
        wr(dpllf_pkg::ADDR_TWLO, tw[31:0]);
        wr(dpllf_pkg::ADDR_TWHI, {16'h0, tw[47:32]});
        wait_tw(tw, 8, n);
        chk({47'h0, n < 8}, 48'h1, "open word");
        rdchk(dpllf_pkg::ADDR_TWRLO, tw[31:0]);
        rdchk(dpllf_pkg::ADDR_TWRHI, {16'h0, tw[47:32]});
        #1 p0 = o_phase;
        @(posedge i_clk);
        #1 chk(o_phase - p0, tw, "phase step");
        @(posedge i_clk);
        i_ce <= 1'b0;
        @(posedge i_clk);
        #1 p0 = o_phase;
        repeat (3) @(posedge i_clk);
        #1 chk(o_phase, p0, "frozen");
        @(posedge i_clk);
        i_ce <= 1'b1;
        @(posedge i_clk);
    endtask : t_open

    // n full feedback pulses give one event; on the last rise, or on the last fall when cfg[1] is set
    task automatic t_div(input logic [15:0] md, input logic [1:0] cfg,
                         input int n);
        logic [31:0] d;
        do_reset();
        wr(dpllf_pkg::ADDR_FBMOD, {16'h0, md});
        wr(dpllf_pkg::ADDR_FBCFG, {30'h0, cfg});
        i_partner.fb_edges(n - 1);
        repeat (6) @(posedge i_clk);
        rd(dpllf_pkg::ADDR_STAT, d);
        chk({47'h0, d[2]}, 48'h0, "early event");
        i_partner.fb_level(1'b1);
        repeat (6) @(posedge i_clk);
        rd(dpllf_pkg::ADDR_STAT, d);
        chk({47'h0, d[2]}, {47'h0, !cfg[1]}, "edge kind");
        i_partner.fb_level(1'b0);
        repeat (6) @(posedge i_clk);
        rd(dpllf_pkg::ADDR_STAT, d);
        chk({47'h0, d[2]}, 48'h1, "event");
    endtask : t_div

    task automatic t_detect(input logic ovf, input logic unf);
        logic [31:0] d;
        logic inr;
        inr = !(ovf || unf);
        i_fine_valid <= 1'b1;
        i_fine_ovf <= ovf;
        i_fine_unf <= unf;
        i_fine_err <= 16'h0010;
        @(posedge i_clk);
        i_fine_valid <= 1'b0;
        @(posedge i_clk);
        i_partner.ref_pulse();
        repeat (6) @(posedge i_clk);
        rd(dpllf_pkg::ADDR_STAT, d);
        chk({46'h0, d[2:1]}, 48'h1, "ref pending");
        i_partner.fb_edges(1);
        repeat (6) @(posedge i_clk);
        rd(dpllf_pkg::ADDR_STAT, d);
        chk({44'h0, d[3:0]}, {44'h0, inr, 2'b00, inr}, "select");
    endtask : t_detect

    task automatic t_closed();
        logic [47:0] tw;
        int n;
        tw = 48'h10_0000;
        do_reset();
        wr(dpllf_pkg::ADDR_TWLO, tw[31:0]);
        wr(dpllf_pkg::ADDR_CTRL, 32'h1);
        wait_tw(tw, 2000, n);
        chk({47'h0, n < 2000}, 48'h1, "dc gain");
        for (int e = 5; e <= 6; e++)
        begin
            wr(dpllf_pkg::ADDR_DECEXP, e);
            wait_tw(tw, 1000, n);
            tw = tw + 48'h10_0000;
            wr(dpllf_pkg::ADDR_TWLO, tw[31:0]);
            wait_tw(tw, 1000, n);
            chk({47'h0, n >= (1 << e) && n <= 3 * (1 << e) + 16}, 48'h1,
                "ramp time");
        end
        i_partner.ref_pulse();
        i_partner.fb_edges(1);
        n = 0;
        while ((o_tuning_word > tw) !== 1'b1 && n < 600)
        begin
            @(posedge i_clk);
            #1 n++;
        end
        chk({47'h0, n < 600}, 48'h1, "steer up");
        wr(dpllf_pkg::ADDR_CTRL, 32'h0);
        wait_tw(tw, 8, n);
        chk({47'h0, n < 8}, 48'h1, "back to open");
    endtask : t_closed

    initial
    begin
        i_arst_n = 1'b0;
        i_ce = 1'b1;
        i_addr = 12'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_fine_valid = 1'b0;
        i_fine_ovf = 1'b0;
        i_fine_unf = 1'b0;
        i_fine_err = 16'h0;
        n_mismatch = 0;
        check_count = 0;
        @(posedge i_clk);
        t_regs();
        t_open();
        t_div(16'h0000, 2'b00, 1);
        t_div(16'h0002, 2'b00, 3);
        t_div(16'h0000, 2'b10, 1);
        t_div(16'h0001, 2'b01, 4);
        t_div(16'h00ff, 2'b00, 256);
        do_reset();
        t_detect(1'b0, 1'b0);
        t_detect(1'b1, 1'b0);
        t_detect(1'b0, 1'b1);
        t_detect(1'b0, 1'b0);
        t_closed();
        print_verdict();
    end

    // guards against a hang in any bounded wait
    initial
    begin
        #200_000;
        n_mismatch++;
        print_verdict();
    end
endmodule : dpllf_top_test
